// ### dv/tb.sv
// Self-checking bench for the clock and power mode controller.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clock_mode_pkg::*;
  logic sys_clk = 0, resetn = 0, internal_fast_rc_osc = 0, internal_slow_rc_osc = 0;
  logic external_crystal_osc = 0, use_fast_rc_option = 1;
  logic halt_req = 0, wake_req = 0, crystal_pin_a_in, crystal_pin_b_in;
  logic crystal_pin_a_out, crystal_pin_a_oe_n, crystal_pin_b_out, crystal_pin_b_oe_n;
  logic [1:0] gpio_out = 2'h0, gpio_oe_n = 2'h3, gpio_in, s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] tick_bits;
  logic high_speed_osc_enable, low_speed_osc_enable;
  logic [2:0] power_mode;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  int n_errors = 0, comparisons = 0, n1, cnt [6];

  // The pins see a pull-up, so a released pin reads high rather than the last driven level.
  assign crystal_pin_a_in = crystal_pin_a_oe_n ? 1'b1 : crystal_pin_a_out;
  assign crystal_pin_b_in = crystal_pin_b_oe_n ? 1'b1 : crystal_pin_b_out;

  system_clock_and_power_mode_control #(.CRYSTAL_READY_COUNT(4), .FAST_RC_READY_COUNT(4)) dut_u
  (.s_axi_wstrb(4'hf), .clk_ticks(tick_bits), .*);

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    forever #410 internal_fast_rc_osc = ~internal_fast_rc_osc;
  end
  initial
  begin
    forever #330 external_crystal_osc = ~external_crystal_osc;
  end
  initial
  begin
    forever #1610 internal_slow_rc_osc = ~internal_slow_rc_osc;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      n_errors++;
    end
  endtask

  task complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task give_up;
    n_errors++;
    complete_run();
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wready)
        s_axi_wvalid <= 0;
      if (s_axi_bvalid)
      begin
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
        break;
      end
    end
    if (i == 40)
      give_up();
  endtask

  task rd_reg(input logic [3:0] a);
    int i;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge sys_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
        break;
      end
    end
    if (i == 40)
      give_up();
  endtask

  // The new mode shows one edge after the edge that samples the request.
  task req(input bit w);
    @(posedge sys_clk);
    if (w)
      wake_req <= 1;
    else
      halt_req <= 1;
    @(posedge sys_clk);
    wake_req <= 0;
    halt_req <= 0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task count(input int n);
    cnt = '{default:0};
    repeat (n)
    begin
      @(posedge sys_clk);
      for (int k = 0; k < 6; k++)
        cnt[k] += (tick_bits[k] === 1'b1);
    end
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    give_up();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1;
    repeat (60) @(posedge sys_clk);
    rd_reg(MODE_CTRL_ADDR);
    check(rd & 32'hf3, 32'h03);
    rd_reg(POWER_CTRL_ADDR);
    check(rd, 32'h0);
    rd_reg(STATUS_ADDR);
    check(rd & 32'h7f, 32'h40);
    rd_reg(4'hc);
    check({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(4'hc, 32'hff);
    check(rsp, RESP_SLVERR);
    @(posedge sys_clk);
    gpio_oe_n <= 2'h2;
    gpio_out <= 2'h1;
    repeat (8) @(posedge sys_clk);
    check({crystal_pin_a_out, crystal_pin_a_oe_n, crystal_pin_b_oe_n, gpio_in}, 5'h17);
    count(320);
    n1 = cnt[4];
    check(32'(n1 > 30), 1);
    wr(MODE_CTRL_ADDR, 32'he2);
    repeat (64) @(posedge sys_clk);
    count(320);
    check(32'(cnt[4] * 2 >= n1 - 3 && cnt[4] * 2 <= n1 + 3), 1);
    wr(POWER_CTRL_ADDR, 32'hc);
    count(320);
    check(32'(cnt[0] * 4 >= cnt[4] - 4 && cnt[0] * 4 <= cnt[4] + 4), 1);
    wr(MODE_CTRL_ADDR, 32'h02);
    repeat (64) @(posedge sys_clk);
    check({high_speed_osc_enable, power_mode}, 4'h1);
    count(160);
    check(32'(cnt[4] >= 4 && cnt[4] <= 6), 1);
    wr(POWER_CTRL_ADDR, 32'h0);
    wr(MODE_CTRL_ADDR, 32'h03);
    repeat (80) @(posedge sys_clk);
    check({high_speed_osc_enable, power_mode}, 4'h8);
    req(0);
    check({high_speed_osc_enable, power_mode}, 4'h2);
    count(100);
    check(32'(cnt[5] == 0 && cnt[1] > 0 && cnt[3] > 0), 1);
    req(1);
    check(power_mode, 3'h0);
    repeat (80) @(posedge sys_clk);
    wr(POWER_CTRL_ADDR, 32'h1);
    req(0);
    check(power_mode, 3'h3);
    count(100);
    check(32'(cnt[5] == 0 && cnt[4] > 0), 1);
    req(1);
    repeat (40) @(posedge sys_clk);
    wr(MODE_CTRL_ADDR, 32'h01);
    wr(POWER_CTRL_ADDR, 32'h2);
    req(0);
    check(power_mode, 3'h4);
    rd_reg(STATUS_ADDR);
    check(rd[4], 1'b1);
    count(100);
    check(32'(cnt[3] > 0 && cnt[2] > 0 && cnt[1] == 0 && cnt[4] == 0), 1);
    req(1);
    wr(STATUS_ADDR, 32'h10);
    rd_reg(STATUS_ADDR);
    check(rd[4], 1'b0);
    wr(POWER_CTRL_ADDR, 32'h0);
    repeat (40) @(posedge sys_clk);
    req(0);
    check(power_mode, 3'h5);
    count(100);
    check(cnt.sum(), 0);
    req(1);
    repeat (80) @(posedge sys_clk);
    // Second reset with the crystal strap: the pins are released and a wake may borrow the slow clock.
    use_fast_rc_option <= 0;
    resetn <= 0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1;
    repeat (60) @(posedge sys_clk);
    check({crystal_pin_a_out, crystal_pin_a_oe_n, crystal_pin_b_oe_n, gpio_in}, 5'h0c);
    rd_reg(STATUS_ADDR);
    check(rd & 32'h7f, 32'h00);
    wr(MODE_CTRL_ADDR, 32'h13);
    req(0);
    check({high_speed_osc_enable, power_mode}, 4'h2);
    req(1);
    rd_reg(STATUS_ADDR);
    check(rd[3:0], 4'h8);
    repeat (60) @(posedge sys_clk);
    rd_reg(STATUS_ADDR);
    check(rd[3:0], 4'h0);
    complete_run();
  end
endmodule

// ### logic/clock_mode_pkg.sv
// Constants, register layout and carrier types for the clock and power mode controller.
package clock_mode_pkg;

  // Nominal source rates, for reference only; neither the bench nor the controller reads them.
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int FAST_RC_HZ = 8_000_000;
  localparam int SLOW_RC_HZ = 32_000;

  // Register byte offsets.
  localparam logic [3:0] MODE_CTRL_ADDR = 4'h0;
  localparam logic [3:0] POWER_CTRL_ADDR = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;

  // Mode control register fields.
  localparam int DIV_SEL_LSB = 5;
  localparam int FAST_WAKE_BIT = 4;
  localparam int LOW_READY_BIT = 3;
  localparam int HIGH_READY_BIT = 2;
  localparam int IDLE_EN_BIT = 1;
  localparam int HL_SEL_BIT = 0;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h03;

  // Power control register fields.
  localparam int SYSON_BIT = 0;
  localparam int LVD_EN_BIT = 1;
  localparam int WDT_EN_BIT = 2;
  localparam int WDT_SYS_BIT = 3;
  localparam logic [3:0] POWER_CTRL_RESET = 4'h0;

  // Status register fields.
  localparam int MODE_LSB = 0;
  localparam int FAST_WAKE_ACTIVE_BIT = 3;
  localparam int REFUSED_BIT = 4;
  localparam int SWITCHING_BIT = 5;
  localparam int FAST_RC_CFG_BIT = 6;

  // Readiness counts in source-clock cycles and the watchdog divider.
  localparam int CRYSTAL_READY_CYCLES = 128;
  localparam int FAST_RC_READY_CYCLES = 16;
  localparam int SLOW_RC_READY_CYCLES = 2;
  localparam logic [1:0] WDT_SYS_DIV_LAST = 2'h3;

  // Effective clock selections: 0 slow source, 1 undivided fast source, 2..7 divided.
  localparam logic [2:0] SEL_LOW = 3'h0;
  localparam logic [2:0] SEL_HIGH = 3'h1;
  localparam logic [2:0] SEL_DIV_FIRST = 3'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {MODE_NORMAL, MODE_SLOW, MODE_IDLE_STOP, MODE_IDLE_RUN,
                            MODE_LIGHT_SLEEP, MODE_DEEP_SLEEP} power_mode_type;

  typedef enum logic [1:0] {SW_STEADY, SW_DRAIN, SW_SKIP} switch_phase_type;

  // One-cycle enable ticks, one per derived clock.
  typedef struct packed {
    logic cpu;
    logic sys;
    logic sub;
    logic slow;
    logic tbc;
    logic wdt;
  } clock_tick_type;

endpackage

// ### logic/system_clock_and_power_mode_control.sv
// Clock source selection, glitch-free switching and power mode sequencing with an AXI4-Lite register slave.
// Overview of operation
// R01: Fast RC supplies fixed 8MHz fast clock.
// R02: Slow RC supplies nominal 32kHz low clock.
// R03: Fast RC chosen: crystal pins are plain I/O.
// R04: Slow oscillator also clocks watchdog and time base.
// R05: System clock chosen by select bit and divider.
// R06: Fast source fixed by static configuration option.
// R07: Normal mode: fast source divided 1 to 64.
// R08: Substitute and time-base clocks from slow RC.
// R09: Substitute clock drives processor right after wake.
// R10: Switching to low clock stops fast oscillator.
// R11: Watchdog clock: substitute or system divided by 4.
// R12: Time-base clock feeds time base and timers.
// R13: Six power modes, two running, four stopped.
// R14: Slow mode runs slow RC, fast clock off.
// R15: Halt with idle disabled enters a sleep mode.
// R16: Deep sleep stops all clocks, watchdog disabled.
// R17: Detector enabled forbids deep sleep entry.
// R18: Light sleep keeps substitute when detector or watchdog.
// R19: Light sleep stops processor, system and time base.
// R20: Halt, idle on, sysclk-on off: oscillator-stopped idle.
// R21: Oscillator-stopped idle keeps substitute and time base.
// R22: Low select: codes 0,1 slow; 2..7 divide 64..2.
// R23: High select uses undivided fast clock.
// R24: Halt, idle on, sysclk-on on: running idle.
// R25: Clock switches produce no short pulses.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
module system_clock_and_power_mode_control
  import clock_mode_pkg::*;
#(
  parameter int CRYSTAL_READY_COUNT = CRYSTAL_READY_CYCLES,
  parameter int FAST_RC_READY_COUNT = FAST_RC_READY_CYCLES
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Oscillator outputs, asynchronous to sys_clk
  input wire logic external_crystal_osc,
  input wire logic internal_fast_rc_osc,
  input wire logic internal_slow_rc_osc,
  // Static configuration option
  input wire logic use_fast_rc_option,
  // Processor requests
  input wire logic halt_req,
  input wire logic wake_req,
  // Crystal-capable pins and their I/O side
  input wire logic crystal_pin_a_in,
  input wire logic crystal_pin_b_in,
  output logic crystal_pin_a_out,
  output logic crystal_pin_a_oe_n,
  output logic crystal_pin_b_out,
  output logic crystal_pin_b_oe_n,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe_n,
  output logic [1:0] gpio_in,
  // Derived clocks and oscillator control
  output clock_tick_type clk_ticks,
  output logic high_speed_osc_enable,
  output logic low_speed_osc_enable,
  output logic [2:0] power_mode,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // The fast-source readiness counter and its limit are eight bits wide, so larger counts would be truncated.
  if (CRYSTAL_READY_COUNT < 1 || CRYSTAL_READY_COUNT > 255 ||
      FAST_RC_READY_COUNT < 1 || FAST_RC_READY_COUNT > 255)
  begin
    $error("ready counts must lie in 1..255");
  end

  function automatic logic [2:0] effective_select(input logic hl, input logic [2:0] code);
    effective_select = hl ? SEL_HIGH : ((code < SEL_DIV_FIRST) ? SEL_LOW : code);
  endfunction

  function automatic logic [5:0] ratio_mask(input logic [2:0] sel);
    case (sel)
      3'h2: ratio_mask = 6'h3f;
      3'h3: ratio_mask = 6'h1f;
      3'h4: ratio_mask = 6'h0f;
      3'h5: ratio_mask = 6'h07;
      3'h6: ratio_mask = 6'h03;
      3'h7: ratio_mask = 6'h01;
      default: ratio_mask = 6'h00;
    endcase
  endfunction

  function automatic logic source_tick(input logic [2:0] sel, input logic ls, input logic hs, input logic [5:0] cnt);
    if (sel == SEL_LOW)
      source_tick = ls;
    else
      source_tick = hs && ((cnt & ratio_mask(sel)) == ratio_mask(sel));
  endfunction

  function automatic logic addr_mapped(input logic [3:0] addr);
    addr_mapped = (addr == MODE_CTRL_ADDR) || (addr == POWER_CTRL_ADDR) || (addr == STATUS_ADDR);
  endfunction

  // Three-stage synchronisers; an oscillator rise counts while stage two is high and stage three still low.
  logic [4:0] sync1, sync2, sync3;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
    end
    else
    begin
      sync1 <= {crystal_pin_b_in, crystal_pin_a_in, internal_slow_rc_osc, internal_fast_rc_osc, external_crystal_osc};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  // The oscillators must toggle below half of sys_clk to be seen; the bench scales them down.
  logic [2:0] osc_rise;
  assign osc_rise = sync2[2:0] & ~sync3[2:0];

  // The fast-source choice is a strap, caught once after reset release.
  logic cfg_loaded, cfg_fast_rc;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_loaded <= 1'b0;
      cfg_fast_rc <= 1'b0;
    end
    else if (!cfg_loaded)
    begin
      cfg_loaded <= 1'b1;
      cfg_fast_rc <= use_fast_rc_option; // R06
    end
  end

  // Registers.
  logic [2:0] div_select;
  logic fast_wake_en, idle_enable, high_low_clock_select;
  logic sysclk_on_in_idle, low_voltage_detect_enable, wdt_enable, wdt_from_sys;
  logic high_ready, low_ready, refused, fast_wake_active;
  power_mode_type mode;
  switch_phase_type phase;
  logic [2:0] sel_cur;
  logic [2:0] sel_target;
  assign sel_target = effective_select(high_low_clock_select, div_select); // R05 R22 R23

  // Fast source ticks: crystal or fast RC, only while that oscillator runs.
  logic hs_tick, ls_tick;
  assign hs_tick = high_speed_osc_enable && (cfg_fast_rc ? osc_rise[1] : osc_rise[0]); // R01 R06
  assign ls_tick = low_speed_osc_enable && osc_rise[2]; // R02 R08

  logic [5:0] hs_count;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      hs_count <= 6'h00;
    else if (hs_tick)
      hs_count <= hs_count + 6'h01; // R07
  end

  // Glitch-free switch: the old source finishes its period, then the first new edge is swallowed.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase <= SW_STEADY;
      sel_cur <= SEL_HIGH;
    end
    else
    begin
      unique case (phase)
        SW_STEADY:
          if (sel_target != sel_cur)
            phase <= SW_DRAIN;
        SW_DRAIN:
          if (source_tick(sel_cur, ls_tick, hs_tick, hs_count))
          begin
            sel_cur <= sel_target; // R25
            phase <= SW_SKIP;
          end
        SW_SKIP:
          if (source_tick(sel_cur, ls_tick, hs_tick, hs_count))
            phase <= SW_STEADY; // R25
      endcase
    end
  end

  logic running;
  assign running = (mode == MODE_NORMAL) || (mode == MODE_SLOW);
  logic deep_allowed;
  assign deep_allowed = !low_voltage_detect_enable && !(wdt_enable && !wdt_from_sys); // R17 R18

  // Power mode sequencing.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mode <= MODE_NORMAL;
    else if (running)
    begin
      if (halt_req)
      begin
        if (idle_enable)
          mode <= sysclk_on_in_idle ? MODE_IDLE_RUN : MODE_IDLE_STOP; // R20 R24
        else
          mode <= deep_allowed ? MODE_DEEP_SLEEP : MODE_LIGHT_SLEEP; // R15 R17
      end
      else
        mode <= (sel_cur == SEL_LOW) ? MODE_SLOW : MODE_NORMAL; // R13 R14
    end
    else if (wake_req)
      mode <= (sel_cur == SEL_LOW) ? MODE_SLOW : MODE_NORMAL;
  end

  // Substitute clock stands in after waking from light sleep or oscillator-stopped idle, which stopped the crystal.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      fast_wake_active <= 1'b0;
    else if (!running && wake_req && fast_wake_en && !cfg_fast_rc && sel_cur != SEL_LOW &&
             (mode == MODE_LIGHT_SLEEP || mode == MODE_IDLE_STOP))
      fast_wake_active <= 1'b1; // R09
    else if (high_ready)
      fast_wake_active <= 1'b0;
  end

  // Oscillator enables.
  logic next_hs_enable, next_ls_enable;
  assign next_hs_enable = (running || mode == MODE_IDLE_RUN) && (sel_cur != SEL_LOW || sel_target != SEL_LOW); // R10 R14
  assign next_ls_enable = mode != MODE_DEEP_SLEEP; // R16
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_speed_osc_enable <= 1'b1;
      low_speed_osc_enable <= 1'b1;
    end
    else
    begin
      high_speed_osc_enable <= next_hs_enable;
      low_speed_osc_enable <= next_ls_enable;
    end
  end

  // Readiness counters, counted on raw oscillator edges once enabled.
  logic [7:0] hs_ready_count;
  logic [1:0] ls_ready_count;
  logic [7:0] hs_ready_limit;
  assign hs_ready_limit = cfg_fast_rc ? 8'(FAST_RC_READY_COUNT) : 8'(CRYSTAL_READY_COUNT);
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_ready_count <= 8'h00;
      high_ready <= 1'b0;
    end
    else if (!high_speed_osc_enable)
    begin
      hs_ready_count <= 8'h00;
      high_ready <= 1'b0;
    end
    else if (hs_tick && !high_ready)
    begin
      hs_ready_count <= hs_ready_count + 8'h01;
      high_ready <= (hs_ready_count + 8'h01) >= hs_ready_limit;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ls_ready_count <= 2'h0;
      low_ready <= 1'b0;
    end
    else if (!low_speed_osc_enable)
    begin
      ls_ready_count <= 2'h0;
      low_ready <= 1'b0;
    end
    else if (ls_tick && !low_ready)
    begin
      ls_ready_count <= ls_ready_count + 2'h1;
      low_ready <= (ls_ready_count + 2'h1) >= 2'(SLOW_RC_READY_CYCLES);
    end
  end

  // Clock gating per mode.
  logic ready_ok, sys_src, sys_on, cpu_on, sub_on, tbc_on;
  assign ready_ok = fast_wake_active || ((sel_cur == SEL_LOW) ? low_ready : high_ready);
  assign sys_src = fast_wake_active ? ls_tick :
                   ((phase == SW_SKIP) ? 1'b0 : source_tick(sel_cur, ls_tick, hs_tick, hs_count)); // R07 R09 R25
  assign cpu_on = running && ready_ok; // R15 R19
  assign sys_on = (running || mode == MODE_IDLE_RUN) && ready_ok; // R21 R24
  assign sub_on = mode != MODE_DEEP_SLEEP; // R16 R18 R21
  assign tbc_on = mode != MODE_DEEP_SLEEP && mode != MODE_LIGHT_SLEEP; // R12 R19

  logic [1:0] sys4_count;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sys4_count <= 2'h0;
    else if (sys_src && sys_on)
      sys4_count <= sys4_count + 2'h1; // R11
  end

  clock_tick_type next_ticks;
  always_comb
  begin
    next_ticks.cpu = sys_src && cpu_on;
    next_ticks.sys = sys_src && sys_on;
    next_ticks.sub = ls_tick && sub_on; // R04 R08
    next_ticks.slow = ls_tick && sub_on;
    next_ticks.tbc = ls_tick && tbc_on; // R04 R12
    if (!wdt_enable || mode == MODE_DEEP_SLEEP)
      next_ticks.wdt = 1'b0; // R16
    else if (wdt_from_sys)
      next_ticks.wdt = sys_src && sys_on && sys4_count == WDT_SYS_DIV_LAST; // R11
    else
      next_ticks.wdt = ls_tick && sub_on;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clk_ticks <= '0;
      power_mode <= 3'h0;
    end
    else
    begin
      clk_ticks <= next_ticks;
      power_mode <= mode;
    end
  end

  // Crystal pins: plain I/O with the fast RC, released to the oscillator otherwise.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      crystal_pin_a_out <= 1'b0;
      crystal_pin_b_out <= 1'b0;
      crystal_pin_a_oe_n <= 1'b1;
      crystal_pin_b_oe_n <= 1'b1;
      gpio_in <= 2'h0;
    end
    else
    begin
      crystal_pin_a_out <= cfg_fast_rc && gpio_out[0]; // R03
      crystal_pin_b_out <= cfg_fast_rc && gpio_out[1];
      crystal_pin_a_oe_n <= !cfg_fast_rc || gpio_oe_n[0]; // R03
      crystal_pin_b_oe_n <= !cfg_fast_rc || gpio_oe_n[1];
      gpio_in <= cfg_fast_rc ? sync3[4:3] : 2'h0;
    end
  end

  // AXI4-Lite handshakes; address and data are taken in either order.
  logic aw_held, w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic write_fire;
  assign write_fire = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (write_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register writes; only byte lane 0 carries bits.
  logic clear_refused;
  assign clear_refused = write_fire && w_lane0 && aw_addr == STATUS_ADDR && w_data[REFUSED_BIT];
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {div_select, fast_wake_en} <= MODE_CTRL_RESET[7:4];
      idle_enable <= MODE_CTRL_RESET[IDLE_EN_BIT];
      high_low_clock_select <= MODE_CTRL_RESET[HL_SEL_BIT];
      {wdt_from_sys, wdt_enable, low_voltage_detect_enable, sysclk_on_in_idle} <= POWER_CTRL_RESET;
    end
    else if (write_fire && w_lane0)
    begin
      if (aw_addr == MODE_CTRL_ADDR)
      begin
        div_select <= w_data[DIV_SEL_LSB +: 3];
        fast_wake_en <= w_data[FAST_WAKE_BIT];
        idle_enable <= w_data[IDLE_EN_BIT];
        high_low_clock_select <= w_data[HL_SEL_BIT];
      end
      if (aw_addr == POWER_CTRL_ADDR)
      begin
        sysclk_on_in_idle <= w_data[SYSON_BIT];
        low_voltage_detect_enable <= w_data[LVD_EN_BIT];
        wdt_enable <= w_data[WDT_EN_BIT];
        wdt_from_sys <= w_data[WDT_SYS_BIT];
      end
    end
  end

  // A deep sleep refused by the detector sets the flag; setting wins over a simultaneous clear.
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      refused <= 1'b0;
    else if (running && halt_req && !idle_enable && low_voltage_detect_enable)
      refused <= 1'b1; // R17
    else if (clear_refused)
      refused <= 1'b0;
  end

  logic [31:0] read_value;
  always_comb
  begin
    read_value = 32'h0;
    if (s_axi_araddr == MODE_CTRL_ADDR)
      read_value[7:0] = {div_select, fast_wake_en, low_ready, high_ready, idle_enable, high_low_clock_select};
    else if (s_axi_araddr == POWER_CTRL_ADDR)
      read_value[3:0] = {wdt_from_sys, wdt_enable, low_voltage_detect_enable, sysclk_on_in_idle};
    else if (s_axi_araddr == STATUS_ADDR)
      read_value[6:0] = {cfg_fast_rc, phase != SW_STEADY, refused, fast_wake_active, mode};
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_value;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  crystal_pins_released_a: assert property (cfg_loaded && !cfg_fast_rc |=> crystal_pin_a_oe_n && crystal_pin_b_oe_n) // R03
    else $error("crystal pins driven while crystal selected");
  deep_all_off_a: assert property (mode == MODE_DEEP_SLEEP |=> clk_ticks == '0) // R16
    else $error("clock tick in deep sleep");
  detector_blocks_deep_a: assert property (running && halt_req && !idle_enable && low_voltage_detect_enable
    |=> mode == MODE_LIGHT_SLEEP && refused) // R17
    else $error("deep sleep entered with detector enabled");
  idle_stop_entry_a: assert property (running && halt_req && idle_enable && !sysclk_on_in_idle
    |=> mode == MODE_IDLE_STOP ##1 !high_speed_osc_enable) // R20
    else $error("halt did not stop oscillator in idle");
  idle_run_entry_a: assert property (running && halt_req && idle_enable && sysclk_on_in_idle
    |=> mode == MODE_IDLE_RUN) // R24
    else $error("halt did not enter running idle");
  slow_fast_off_a: assert property (mode == MODE_SLOW && sel_target == SEL_LOW && phase == SW_STEADY
    |=> !high_speed_osc_enable) // R10
    else $error("fast oscillator running in slow mode");
  switch_swallow_a: assert property (phase == SW_SKIP && !fast_wake_active |=> !clk_ticks.sys) // R25
    else $error("tick passed during switch skip");
  light_gated_a: assert property (mode == MODE_LIGHT_SLEEP |=> !clk_ticks.cpu && !clk_ticks.sys && !clk_ticks.tbc) // R19
    else $error("clock running in light sleep");
  wdt_quarter_a: assert property (wdt_enable && wdt_from_sys && mode != MODE_DEEP_SLEEP && sys_src && sys_on
    && sys4_count == WDT_SYS_DIV_LAST |=> clk_ticks.wdt) // R11
    else $error("watchdog missed system quarter tick");
  idle_stop_cpu_a: assert property (mode == MODE_IDLE_STOP |=> !clk_ticks.cpu && !clk_ticks.sys) // R21
    else $error("processor clock in stopped idle");

  deep_entry_c: cover property (running && halt_req ##1 mode == MODE_DEEP_SLEEP);
  light_entry_c: cover property (running && halt_req ##1 mode == MODE_LIGHT_SLEEP);
  switch_done_c: cover property (phase == SW_SKIP ##1 phase == SW_STEADY);
  fast_wake_c: cover property (fast_wake_active ##1 !fast_wake_active);

endmodule
